// file: logic/lis_pkg.sv
/*
 * constants, field positions and state codes for the lcd input select block.
 * assumes a 125 MHz system clock and a slower external shift clock.
 */
`default_nettype none
package lis_pkg;
  // data path widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  // bits accepted per line before deselect
  localparam logic [CNT_W-1:0] LINE_BITS = 8'hA0;
  localparam logic [CNT_W-1:0] NIB_STEP = 8'h04;
  localparam logic [CNT_W-1:0] BYTE_STEP = 8'h08;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  // positions inside the synchroniser vector
  localparam int unsigned SY_DATA_LO = 0;
  localparam int unsigned SY_SCK = 8;
  localparam int unsigned SY_LP = 9;
  localparam int unsigned SY_PIN_A = 10;
  localparam int unsigned SY_PIN_B = 11;
  localparam int unsigned SY_WIDE = 12;
  localparam int unsigned SY_COMMON = 13;
  localparam int unsigned SY_DIR = 14;
  localparam int unsigned SYNC_W = 15;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 15'h0000;
  // selection sequence, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARMED = 4'h2,
    ST_SELECT = 4'h4,
    ST_DONE = 4'h8
  } lis_state_t;
endpackage
`default_nettype wire

// file: logic/lis_fifo.sv
/*
 * shift-register fifo; the head entry and all flags are flip-flops.
 * assumes a reset already synchronised to clock.
 */
`timescale 1ns/10ps
`default_nettype none
module lis_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic pop;
  logic push;
  logic placed;

  // head and full flag straight from flops
  assign out_data = mem_q[0];
  assign out_valid = vld_q[0];
  assign in_ready = ~vld_q[DEPTH-1];
  assign pop = vld_q[0] & out_ready;
  assign push = in_valid & ~vld_q[DEPTH-1];

  // shift down on pop, then fill the first free slot
  always_comb begin
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem_d[i] = mem_q[i+1];
        vld_d[i] = vld_q[i+1];
      end else if (pop) begin
        mem_d[i] = mem_q[i];
        vld_d[i] = 1'b0;
      end else begin
        mem_d[i] = mem_q[i];
        vld_d[i] = vld_q[i];
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !placed && !vld_d[i]) begin
        mem_d[i] = in_data;
        vld_d[i] = 1'b1;
        placed = 1'b1;
      end
    end
  end

  // storage registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      vld_q <= vld_d;
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

// file: logic/lis_input_select.sv
/*
 * active control and serial to parallel capture of an lcd driver input.
 * assumes all pins are asynchronous to clock and the shift clock runs
 * well below a quarter of the clock rate; a consumer drains byte_data.
 */
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1: segment mode keeps an active control deciding chip selected or not.
// RULE2: accept data only after line latch, then chip select, in order.
// RULE3: keep select active until exactly 160 data bits are captured. The code also drops select back to ST_ARMED on a latch pulse.
// RULE4: after the last bit drive cascade select out and deselect.
// RULE5: common mode uses active control for bidirectional pin direction.
// RULE6: 4-bit width joins two shift clocks into one held byte.
// RULE7: 8-bit width takes one byte per shift clock.
// RULE8: each held byte goes onto the internal bus one byte at once.
// RULE9: deselected ignores shift clocks until next latch and select.
module lis_input_select
  import lis_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic data_shift_clock,
  input wire logic line_latch_pulse,
  input wire logic [lis_pkg::DATA_W-1:0] display_data_inputs,
  input wire logic wide_mode,
  input wire logic common_mode,
  input wire logic common_dir,
  input wire logic cascade_a_in,
  output logic cascade_a_out,
  output logic cascade_a_oe,
  input wire logic cascade_b_in,
  output logic cascade_b_out,
  output logic cascade_b_oe,
  output logic chip_selected,
  output logic overrun,
  output logic [lis_pkg::DATA_W-1:0] byte_data,
  output logic byte_valid,
  input wire logic byte_ready
);
  import lis_pkg::*;

  logic rst_s1_q;
  logic rst_s2_q;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic sck_prev_q;
  logic lp_prev_q;
  logic sck_fall;
  logic lp_rise;
  logic [DATA_W-1:0] din;
  logic pin_a;
  logic pin_b;
  logic wide;
  logic common;
  logic dir;
  lis_state_t state_q;
  lis_state_t state_d;
  logic [CNT_W-1:0] bits_q;
  logic [CNT_W-1:0] bits_d;
  logic [NIB_W-1:0] nib_q;
  logic [NIB_W-1:0] nib_d;
  logic phase_q;
  logic phase_d;
  logic push_valid_q;
  logic push_valid_d;
  logic [DATA_W-1:0] push_data_q;
  logic [DATA_W-1:0] push_data_d;
  logic overrun_q;
  logic overrun_d;
  logic sel_q;
  logic sel_d;
  logic a_out_q;
  logic a_out_d;
  logic a_oe_q;
  logic a_oe_d;
  logic b_out_q;
  logic b_out_d;
  logic b_oe_q;
  logic b_oe_d;
  logic fifo_in_ready;
  logic byte_made;
  logic [DATA_W-1:0] byte_new;
  logic [CNT_W-1:0] bits_next;

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // two-flop synchronisers and edge history
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
      sck_prev_q <= 1'b0;
      lp_prev_q <= 1'b0;
    end else begin
      sync1_q <= {common_dir, common_mode, wide_mode, cascade_b_in,
                  cascade_a_in, line_latch_pulse, data_shift_clock,
                  display_data_inputs};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[SY_SCK];
      lp_prev_q <= sync2_q[SY_LP];
    end
  end

  // decoded synchronised inputs
  assign din = sync2_q[SY_DATA_LO +: DATA_W];
  assign pin_a = sync2_q[SY_PIN_A];
  assign pin_b = sync2_q[SY_PIN_B];
  assign wide = sync2_q[SY_WIDE];
  assign common = sync2_q[SY_COMMON];
  assign dir = sync2_q[SY_DIR];
  assign sck_fall = sck_prev_q & ~sync2_q[SY_SCK];
  assign lp_rise = ~lp_prev_q & sync2_q[SY_LP];

  // selection sequence and capture
  always_comb begin
    state_d = state_q;
    bits_d = bits_q;
    nib_d = nib_q;
    phase_d = phase_q;
    sel_d = 1'b0;
    byte_made = 1'b0;
    byte_new = DATA_RESET;
    bits_next = bits_q;
    if (common) begin
      state_d = ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_DONE: begin
          // RULE9: ignore shift clocks while deselected
          if (lp_rise) begin
            state_d = ST_ARMED;
          end
        end
        ST_ARMED: begin
          // RULE2: select only after latch then chip select
          if (pin_a) begin
            state_d = ST_SELECT;
            bits_d = CNT_RESET;
            phase_d = 1'b0;
          end
        end
        ST_SELECT: begin
          if (sck_fall && wide) begin
            // RULE7: one clock gives a byte
            byte_made = 1'b1;
            byte_new = din;
            bits_next = bits_q + BYTE_STEP;
          end else if (sck_fall && !phase_q) begin
            // RULE6: first nibble held
            nib_d = din[NIB_W-1:0];
            phase_d = 1'b1;
            bits_next = bits_q + NIB_STEP;
          end else if (sck_fall) begin
            // RULE6: second nibble completes byte
            byte_made = 1'b1;
            byte_new = {nib_q, din[NIB_W-1:0]};
            phase_d = 1'b0;
            bits_next = bits_q + NIB_STEP;
          end
          bits_d = bits_next;
          // RULE3: deselect at exactly the line count
          if (bits_next >= LINE_BITS) begin
            state_d = ST_DONE;
          end else if (lp_rise) begin
            state_d = ST_ARMED;
          end
        end
      endcase
    end
    // RULE1: selected flag set while the next state is ST_SELECT
    sel_d = (state_d == ST_SELECT);
  end

  // byte hand-off towards the fifo
  always_comb begin
    push_valid_d = push_valid_q & ~fifo_in_ready;
    push_data_d = push_data_q;
    overrun_d = overrun_q & ~lp_rise;
    if (byte_made) begin
      // RULE8: byte onto the internal bus
      push_valid_d = 1'b1;
      push_data_d = byte_new;
      if (push_valid_q && !fifo_in_ready) begin
        overrun_d = 1'b1; // lost byte, set beats clear
      end
    end
  end

  // pin drive and direction
  always_comb begin
    if (common) begin
      // RULE5: direction chosen in common mode
      a_oe_d = dir;
      b_oe_d = ~dir;
      a_out_d = dir & pin_b;
      b_out_d = ~dir & pin_a;
    end else begin
      // RULE4: cascade select once line complete
      a_oe_d = 1'b0;
      a_out_d = 1'b0;
      b_oe_d = 1'b1;
      b_out_d = (state_d == ST_DONE);
    end
  end

  // state registers
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= ST_IDLE;
      bits_q <= CNT_RESET;
      nib_q <= NIB_RESET;
      phase_q <= 1'b0;
      sel_q <= 1'b0;
      push_valid_q <= 1'b0;
      push_data_q <= DATA_RESET;
      overrun_q <= 1'b0;
      a_out_q <= 1'b0;
      a_oe_q <= 1'b0;
      b_out_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bits_q <= bits_d;
      nib_q <= nib_d;
      phase_q <= phase_d;
      sel_q <= sel_d;
      push_valid_q <= push_valid_d;
      push_data_q <= push_data_d;
      overrun_q <= overrun_d;
      a_out_q <= a_out_d;
      a_oe_q <= a_oe_d;
      b_out_q <= b_out_d;
      b_oe_q <= b_oe_d;
    end
  end

  // four-entry buffer in the byte path
  lis_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_s2_q),
    .in_valid(push_valid_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(byte_valid),
    .out_ready(byte_ready),
    .out_data(byte_data)
  );

  assign chip_selected = sel_q;
  assign overrun = overrun_q;
  assign cascade_a_out = a_out_q;
  assign cascade_a_oe = a_oe_q;
  assign cascade_b_out = b_out_q;
  assign cascade_b_oe = b_oe_q;
endmodule
`default_nettype wire

// file: dv/lis_input_select_monitor.sv
/* checker on the lis_input_select ports
   assumes a bind from the bench top */
`timescale 1ns/10ps
`default_nettype none
module lis_input_select_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic data_shift_clock,
  input wire logic wide_mode,
  input wire logic common_mode,
  input wire logic common_dir,
  input wire logic cascade_a_in,
  input wire logic cascade_a_oe,
  input wire logic cascade_b_oe,
  input wire logic cascade_b_out,
  input wire logic chip_selected,
  input wire logic overrun,
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  input wire logic byte_ready
);
  logic sck_q;
  logic [7:0] fall_q;
  logic [7:0] fall_d;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // shift clock falls counted while selected
  always_comb begin
    fall_d = chip_selected ? fall_q + 8'(sck_q & ~data_shift_clock) : 8'h00;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      fall_q <= 8'h00;
    end else begin
      sck_q <= data_shift_clock;
      fall_q <= fall_d;
    end
  end
  AST_CASC_DESEL: assert property (
    $rose(cascade_b_out) && !common_mode |-> $fell(chip_selected))
    else $error("cascade without deselect");
  AST_BIT_COUNT: assert property (
    $rose(cascade_b_out) && !common_mode |->
      fall_q == (wide_mode ? 8'h14 : 8'h28))
    else $error("select length wrong");
  AST_SEL_EXCL: assert property (
    !common_mode && chip_selected |-> !cascade_b_out)
    else $error("selected with cascade high");
  AST_BYTE_HOLD: assert property (
    byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
    else $error("byte changed before taken");
  AST_CS_FIRST: assert property (
    !cascade_a_in [*8] |-> !$rose(chip_selected))
    else $error("selected without chip select");
  AST_COMMON_IDLE: assert property (
    common_mode [*8] |-> !chip_selected)
    else $error("selected in common mode");
  AST_DIR_B: assert property (
    (common_mode && !common_dir) [*6] |-> cascade_b_oe && !cascade_a_oe)
    else $error("pin b not driving");
  AST_DIR_A: assert property (
    (common_mode && common_dir) [*6] |-> cascade_a_oe && !cascade_b_oe)
    else $error("pin a not driving");
  // main scenarios reached
  cover property ($rose(cascade_b_out) && !wide_mode);
  cover property ($rose(overrun));
  cover property (common_mode && cascade_a_oe);
endmodule
`default_nettype wire

// file: dv/lis_ctl_model.sv
/* display controller model: latch, select, shift clock, data
   assumes the bench clock; bytes of lines sent with note set are noted in exp_q */
`timescale 1ns/10ps
`default_nettype none
module lis_ctl_model (
  input wire logic clock,
  output logic shift_clk,
  output logic latch_pulse,
  output logic cs,
  output logic [7:0] din
);
  logic [7:0] exp_q[$];
  logic [7:0] b;
  // shift clock rests low outside lines
  initial begin
    shift_clk = 1'b0;
    latch_pulse = 1'b0;
    cs = 1'b0;
    din = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // data held across the falling edge
  task automatic shift(input logic [7:0] v);
    din = v;
    shift_clk = 1'b1;
    tick(4);
    shift_clk = 1'b0;
    tick(4);
  endtask
  task automatic line(input logic wide, input logic lat, input logic note);
    latch_pulse = lat;
    tick(4);
    latch_pulse = 1'b0;
    tick(4);
    cs = 1'b1;
    tick(16);
    for (int i = 0; i < 20; i++) begin
      b = 8'($urandom);
      if (note) exp_q.push_back(b);
      if (!wide) shift({4'($urandom), b[7:4]});
      shift(wide ? b : {4'($urandom), b[3:0]});
    end
    cs = 1'b0;
    din = ~din;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/* self-checking bench for lis_input_select
   assumes the controller model and the bound monitor */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wide = 1'b1;
  logic cmn = 1'b0;
  logic dir = 1'b0;
  logic rdy = 1'b0;
  logic stall = 1'b0;
  logic quiet = 1'b0;
  logic tb_a = 1'b0;
  logic tb_b = 1'b0;
  logic sck, lat, cs, a_out, a_oe, b_out, b_oe, sel, ovr, bv;
  logic [7:0] din, bd;
  int n_fail = 0;
  int samples_checked = 0;
  // pin levels from every driver enable
  wire logic pin_a = a_oe ? a_out : (cmn ? tb_a : cs);
  wire logic pin_b = b_oe ? b_out : tb_b;
  always #4 clock = ~clock;
  lis_ctl_model u_ctl (.clock(clock), .shift_clk(sck), .latch_pulse(lat),
    .cs(cs), .din(din));
  lis_input_select u_dut (.clock(clock), .rst_n(rst_n),
    .data_shift_clock(sck), .line_latch_pulse(lat),
    .display_data_inputs(din), .wide_mode(wide), .common_mode(cmn),
    .common_dir(dir), .cascade_a_in(pin_a), .cascade_a_out(a_out),
    .cascade_a_oe(a_oe), .cascade_b_in(pin_b), .cascade_b_out(b_out),
    .cascade_b_oe(b_oe), .chip_selected(sel), .overrun(ovr),
    .byte_data(bd), .byte_valid(bv), .byte_ready(rdy));
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // consumer: random ready, taken bytes against oldest note
  always @(posedge clock) begin
    if (bv && rdy && !quiet) begin
      if (u_ctl.exp_q.size() == 0) check("spare byte", 8'h01, 8'h00);
      else check("byte_data", bd, u_ctl.exp_q.pop_front());
    end
    #1 rdy = stall ? 1'b0 : ($urandom % 4 != 0);
  end
  initial begin
    #200us;
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h0B4D));
    wait_n(16);
    rst_n = 1'b1;
    wait_n(8);
    // whole lines in 8-bit then 4-bit width
    for (int w = 1; w >= 0; w--) begin
      wide = w[0];
      wait_n(8);
      u_ctl.line(w[0], 1'b1, 1'b1);
      wait_n(16);
      check("chip_selected", 8'(sel), 8'h00);
      check("cascade_b_out", 8'(b_out), 8'h01);
      check("bytes left", 8'(u_ctl.exp_q.size()), 8'h00);
      $display("test line width %0d done", w ? 8 : 4);
    end
    // select without a fresh latch pulse, back in 8-bit width
    wide = 1'b1;
    u_ctl.line(1'b1, 1'b0, 1'b0);
    check("chip_selected", 8'(sel), 8'h00);
    $display("test refused select done");
    // consumer stalls a whole line, buffer refuses
    stall = 1'b1;
    quiet = 1'b1;
    u_ctl.line(1'b1, 1'b1, 1'b0);
    check("overrun", 8'(ovr), 8'h01);
    stall = 1'b0;
    wait_n(40);
    quiet = 1'b0;
    u_ctl.line(1'b1, 1'b1, 1'b1);
    wait_n(16);
    check("overrun", 8'(ovr), 8'h00);
    check("bytes left", 8'(u_ctl.exp_q.size()), 8'h00);
    $display("test overrun done");
    // common mode: direction and copied pin
    cmn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      dir = k[1];
      tb_a = k[0];
      tb_b = k[0];
      wait_n(8);
      check("a_oe", 8'(a_oe), 8'(k[1]));
      check("b_oe", 8'(b_oe), 8'(!k[1]));
      check("copy", 8'(k[1] ? a_out : b_out), 8'(k[0]));
    end
    tb_a = 1'b0;
    tb_b = 1'b0;
    wait_n(8);
    cmn = 1'b0;
    wait_n(8);
    $display("test common mode done");
    give_verdict();
  end
endmodule
bind lis_input_select lis_input_select_monitor u_mon (.clock, .rst_n,
  .data_shift_clock, .wide_mode, .common_mode, .common_dir, .cascade_a_in,
  .cascade_a_oe, .cascade_b_oe, .cascade_b_out, .chip_selected, .overrun,
  .byte_data, .byte_valid, .byte_ready);
`default_nettype wire
